// >>> hdl/pahc_axis.sv
// Pulse output axis with origin return sequencing, clear output and flags.
// Assumes a master on the plain register port synchronous to clk_sys and
// near-point and zero-point sensor pins asynchronous to it.
//
// Functional notes
// - Completion pulses interrupt only when enabled
// - Monitor flag low while channel idle
// - Clear output only when clear enabled
// - Select flag routes clear to indexed element
// - Search return direction follows direction flag
// - Forward limit flag means forward limit reached
// - Reverse limit flag means reverse limit reached
// - Default clear pulse lasts 20 ms plus scan
`timescale 1ns/1ns
`include "pahc_defs.svh"
module pahc_axis
  import pahc_pkg::*;
#(
  parameter int unsigned CLR_CYCLES  = `PAHC_CLR_CYCLES,
  parameter int unsigned SCAN_CYCLES = `PAHC_SCAN_CYCLES,
  parameter int unsigned NUM_ELEM    = 16
)
(
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  // Register port
  input  wire logic [`PAHC_ADDR_W-1:0] reg_addr,
  input  wire logic [`PAHC_DATA_W-1:0] reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [`PAHC_DATA_W-1:0] reg_rdata,
  // Sensor pins
  input  wire logic                    near_point_in,
  input  wire logic                    zero_point_in,
  // Drive side outputs
  output logic                         axis_pulse_output,
  output logic                         axis_dir_out,
  output logic      [NUM_ELEM-1:0]     drive_clear_signal,
  output logic                         completion_irq
);

  // Clear pulse length in cycles less one, loaded as a down counter
  localparam logic [31:0] CLR_LOAD = 32'(CLR_CYCLES + SCAN_CYCLES - 1);

  // Whole state of the axis
  typedef struct packed {
    logic [`PAHC_CTRL_W-1:0] ctrl;
    logic [3:0]              clr_idx;
    logic [15:0]             fast_hp;
    logic [15:0]             creep_hp;
    pahc_state_t             state;
    pahc_kind_t              kind;
    logic                    move_fwd;
    logic [15:0]             hp_cnt;
    logic                    pulse;
    logic [15:0]             pos;
    logic                    arrived;
    logic [31:0]             clr_cnt;
    logic [NUM_ELEM-1:0]     clr_vec;
    logic                    irq;
    logic [15:0]             rdata;
  } pahc_axis_st_t;

  pahc_axis_st_t st_ff;
  pahc_axis_st_t nxt_st;

  logic [1:0] pins_sync;
  logic       near_pt;
  logic       zero_pt;
  logic       busy;
  logic       wr_cmd;
  logic [15:0] hp_sel;
  logic       start_req;
  logic       abort_req;

  // Sensor pins cross into clk_sys
  pahc_sync #(
    .W (2)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     ({near_point_in, zero_point_in}),
    .dout    (pins_sync)
  );

  // Synchronised pins, near point in the upper bit
  assign near_pt = pins_sync[1];
  assign zero_pt = pins_sync[0];

  assign busy   = (st_ff.state == PAHC_SEEK) || (st_ff.state == PAHC_CREEP);
  assign wr_cmd = reg_wr && (reg_addr == `PAHC_REG_CMD);

  // Command decode: abort wins, search or plain starts a return
  assign abort_req = wr_cmd && reg_wdata[`PAHC_CMD_ABORT];
  assign start_req = wr_cmd && !reg_wdata[`PAHC_CMD_ABORT]
                     && (reg_wdata[`PAHC_CMD_SEARCH] || reg_wdata[`PAHC_CMD_PLAIN]);

  // Half period of the current motion phase
  assign hp_sel = (st_ff.state == PAHC_CREEP) ? st_ff.creep_hp : st_ff.fast_hp;

  // Reload value of the half-period counter, zero treated as one cycle
  function automatic logic [15:0] pahc_reload(input logic [15:0] hp);
    logic [15:0] r;
    r = (hp == 16'h0000) ? 16'h0000 : hp - 16'h0001;
    return r;
  endfunction : pahc_reload

  // Next-state logic: register port, sequencer, pulse and clear timing
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.irq   = 1'b0;
    nxt_st.rdata = 16'h0000;

    // Read data, valid in the cycle after the read strobe
    if (reg_rd)
    begin
      case (reg_addr)
        `PAHC_REG_CTRL:
        begin
          nxt_st.rdata = {10'h000, st_ff.ctrl};
        end
        `PAHC_REG_STATUS:
        begin
          nxt_st.rdata[`PAHC_STAT_BUSY]     = busy;
          nxt_st.rdata[`PAHC_STAT_DIR_NOW]  = st_ff.move_fwd;
          nxt_st.rdata[`PAHC_STAT_CLEARING] = (st_ff.state == PAHC_CLEAR);
          nxt_st.rdata[`PAHC_STAT_ARRIVED]  = st_ff.arrived;
        end
        `PAHC_REG_CLR_IDX:
        begin
          nxt_st.rdata = {12'h000, st_ff.clr_idx};
        end
        `PAHC_REG_FAST_HP:
        begin
          nxt_st.rdata = st_ff.fast_hp;
        end
        `PAHC_REG_CREEP_HP:
        begin
          nxt_st.rdata = st_ff.creep_hp;
        end
        `PAHC_REG_POS:
        begin
          nxt_st.rdata = st_ff.pos;
        end
        // Command register is write-only and reads zero
        `PAHC_REG_CMD:
        begin
          nxt_st.rdata = 16'h0000;
        end
        default:
        begin
          nxt_st.rdata = 16'h0000;
        end
      endcase
    end

    // Register writes; the command register is handled by the sequencer
    if (reg_wr)
    begin
      case (reg_addr)
        `PAHC_REG_CTRL:
        begin
          nxt_st.ctrl = reg_wdata[`PAHC_CTRL_W-1:0];
        end
        `PAHC_REG_STATUS:
        begin
          if (reg_wdata[`PAHC_STAT_ARRIVED])
          begin
            nxt_st.arrived = 1'b0;  // Write one to clear
          end
        end
        `PAHC_REG_CLR_IDX:
        begin
          nxt_st.clr_idx = reg_wdata[3:0];
        end
        `PAHC_REG_FAST_HP:
        begin
          nxt_st.fast_hp = reg_wdata;
        end
        `PAHC_REG_CREEP_HP:
        begin
          nxt_st.creep_hp = reg_wdata;
        end
        // Position is read-only: writes leave it alone
        `PAHC_REG_POS:
        begin
          nxt_st.pos = st_ff.pos;
        end
        default:
        begin
          nxt_st.ctrl = nxt_st.ctrl;
        end
      endcase
    end

    // Homing sequencer
    case (st_ff.state)
      PAHC_IDLE:
      begin
        nxt_st.pulse = 1'b0;
        if (start_req)
        begin
          nxt_st.kind   = reg_wdata[`PAHC_CMD_SEARCH] ? PAHC_KIND_SEARCH
                                                     : PAHC_KIND_PLAIN;
          nxt_st.move_fwd = st_ff.ctrl[`PAHC_CTRL_DIR];
          nxt_st.hp_cnt   = pahc_reload(st_ff.fast_hp);
          nxt_st.pos      = 16'h0000;
          nxt_st.state    = PAHC_SEEK;
        end
      end

      PAHC_SEEK, PAHC_CREEP:
      begin
        // Square wave on the pulse output, one step per rising edge
        if (st_ff.hp_cnt == 16'h0000)
        begin
          nxt_st.pulse  = !st_ff.pulse;
          nxt_st.hp_cnt = pahc_reload(hp_sel);
          if (!st_ff.pulse)
          begin
            nxt_st.pos = st_ff.pos + 16'h0001;
          end
        end
        else
        begin
          nxt_st.hp_cnt = st_ff.hp_cnt - 16'h0001;
        end

        // Limits steer only a search; both set flips direction every cycle
        if (st_ff.kind == PAHC_KIND_SEARCH)
        begin
          if (st_ff.move_fwd && st_ff.ctrl[`PAHC_CTRL_FWD_LIM])
          begin
            nxt_st.move_fwd = 1'b0;
          end
          else if (!st_ff.move_fwd && st_ff.ctrl[`PAHC_CTRL_REV_LIM])
          begin
            nxt_st.move_fwd = 1'b1;
          end
        end

        // Near point drops to creep speed
        if ((st_ff.state == PAHC_SEEK) && near_pt)
        begin
          nxt_st.state  = PAHC_CREEP;
          nxt_st.hp_cnt = pahc_reload(st_ff.creep_hp);
        end

        // Zero point while creeping is origin arrival
        if ((st_ff.state == PAHC_CREEP) && zero_pt)
        begin
          nxt_st.pulse   = 1'b0;
          nxt_st.arrived = 1'b1;  // Set after the clear above, so set wins
          nxt_st.irq     = st_ff.ctrl[`PAHC_CTRL_CIE];
          if (st_ff.ctrl[`PAHC_CTRL_CLR_EN])
          begin
            if (st_ff.ctrl[`PAHC_CTRL_CLR_SEL])
            begin
              nxt_st.clr_vec = NUM_ELEM'(1) << st_ff.clr_idx;
            end
            else
            begin
              nxt_st.clr_vec = NUM_ELEM'(1) << `PAHC_DEF_CLR_ELEM;
            end
            nxt_st.clr_cnt = CLR_LOAD;
            nxt_st.state   = PAHC_CLEAR;
          end
          else
          begin
            nxt_st.state = PAHC_IDLE;
          end
        end
      end

      PAHC_CLEAR:
      begin
        nxt_st.pulse = 1'b0;
        if (st_ff.clr_cnt == 32'h0000_0000)
        begin
          nxt_st.clr_vec = '0;
          nxt_st.state   = PAHC_IDLE;
        end
        else
        begin
          nxt_st.clr_cnt = st_ff.clr_cnt - 32'h0000_0001;
        end
      end

      default:
      begin
        nxt_st.state = PAHC_IDLE;
      end
    endcase

    // Abort stops motion and any clear pulse at once
    if (abort_req)
    begin
      nxt_st.state   = PAHC_IDLE;
      nxt_st.pulse   = 1'b0;
      nxt_st.clr_vec = '0;
      nxt_st.irq     = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff          <= '0;
      st_ff.ctrl     <= `PAHC_CTRL_RST;
      st_ff.clr_idx  <= `PAHC_CLR_IDX_RST;
      st_ff.fast_hp  <= `PAHC_FAST_HP_RST;
      st_ff.creep_hp <= `PAHC_CREEP_HP_RST;
      st_ff.state    <= PAHC_IDLE;
      st_ff.kind     <= PAHC_KIND_SEARCH;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata          = st_ff.rdata;
  assign axis_pulse_output  = st_ff.pulse;
  assign axis_dir_out       = st_ff.move_fwd;
  assign drive_clear_signal = st_ff.clr_vec;
  assign completion_irq     = st_ff.irq;

endmodule : pahc_axis

// >>> hdl/pahc_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ns
module pahc_sync
  import pahc_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // Pin side
  input  wire logic [W-1:0] din,
  // Synchronised side
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pahc_sync_st_t;

  pahc_sync_st_t st_ff;
  pahc_sync_st_t nxt_st;

  // First stage feeds only the second stage
  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.s2;

endmodule : pahc_sync

// >>> inc/pahc_defs.svh
// Constants of the pulse axis homing controller: offsets, bit positions,
// reset values and timing counts. Included by the top module, the monitor and the testbench.
`ifndef PAHC_DEFS_SVH
`define PAHC_DEFS_SVH

// Register word offsets on the plain register port
`define PAHC_ADDR_W          4
`define PAHC_DATA_W          16
`define PAHC_REG_CTRL        4'h0
`define PAHC_REG_STATUS      4'h1
`define PAHC_REG_CLR_IDX     4'h2
`define PAHC_REG_CMD         4'h3
`define PAHC_REG_FAST_HP     4'h4
`define PAHC_REG_CREEP_HP    4'h5
`define PAHC_REG_POS         4'h6

// Control register bit positions
`define PAHC_CTRL_W          6
`define PAHC_CTRL_CIE        0
`define PAHC_CTRL_CLR_EN     1
`define PAHC_CTRL_CLR_SEL    2
`define PAHC_CTRL_DIR        3
`define PAHC_CTRL_FWD_LIM    4
`define PAHC_CTRL_REV_LIM    5

// Status register bit positions
`define PAHC_STAT_BUSY       0
`define PAHC_STAT_DIR_NOW    1
`define PAHC_STAT_CLEARING   2
`define PAHC_STAT_ARRIVED    3

// Command register bit positions
`define PAHC_CMD_SEARCH      0
`define PAHC_CMD_PLAIN       1
`define PAHC_CMD_ABORT       2

// Reset values
`define PAHC_CTRL_RST        6'h00
`define PAHC_CLR_IDX_RST     4'h0
`define PAHC_FAST_HP_RST     16'h0032
`define PAHC_CREEP_HP_RST    16'h01F4
`define PAHC_DEF_CLR_ELEM    4'hE

// Timing: clock rate, clear pulse time and one scan time
`define PAHC_CLK_HZ          10000000
`define PAHC_CLR_TIME_MS     20
`define PAHC_SCAN_TIME_US    1000
`define PAHC_CLR_CYCLES      ((`PAHC_CLR_TIME_MS * `PAHC_CLK_HZ) / 1000)
`define PAHC_SCAN_CYCLES     ((`PAHC_SCAN_TIME_US * `PAHC_CLK_HZ) / 1000000)

`endif

// >>> inc/pahc_pkg.sv
// Types of the pulse axis homing controller.
// Assumes nothing of its surroundings.
package pahc_pkg;

  // Homing sequencer states
  typedef enum logic [1:0]
  {
    PAHC_IDLE,
    PAHC_SEEK,
    PAHC_CREEP,
    PAHC_CLEAR
  } pahc_state_t;

  // Kind of origin return in progress
  typedef enum logic
  {
    PAHC_KIND_SEARCH,
    PAHC_KIND_PLAIN
  } pahc_kind_t;

endpackage : pahc_pkg

// >>> tb/pahc_axis_monitor.sv
// Port checker of the homing axis: irq, clear routing and clear width.
// Assumes the ports of pahc_axis; bound to it at the foot of this file.
`timescale 1ns/1ns
`include "pahc_defs.svh"
module pahc_axis_monitor
  import pahc_pkg::*;
#(
  parameter int unsigned CLR_CYCLES  = 20,
  parameter int unsigned SCAN_CYCLES = 5,
  parameter int unsigned NUM_ELEM    = 16
)
(
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    rst_b,
  // Register port
  input wire logic [`PAHC_ADDR_W-1:0] reg_addr,
  input wire logic [`PAHC_DATA_W-1:0] reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [`PAHC_DATA_W-1:0] reg_rdata,
  // Drive side
  input wire logic                    axis_pulse_output,
  input wire logic [NUM_ELEM-1:0]     drive_clear_signal,
  input wire logic                    completion_irq
);
  logic [5:0]  ctrl_ff;
  logic [3:0]  idx_ff;
  int unsigned hi_ff;
  logic        clr_on;

  assign clr_on = |drive_clear_signal;

  // Shadow of written control and index, and clear high time
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_ff <= 6'h00;
      idx_ff  <= 4'h0;
      hi_ff   <= 0;
    end
    else
    begin
      if (reg_wr && reg_addr == `PAHC_REG_CTRL)
        ctrl_ff <= reg_wdata[5:0];
      if (reg_wr && reg_addr == `PAHC_REG_CLR_IDX)
        idx_ff <= reg_wdata[3:0];
      hi_ff <= clr_on ? hi_ff + 1 : 0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_irq_gated: assert property (
    completion_irq |-> ctrl_ff[`PAHC_CTRL_CIE]) else $error("irq while disabled");
  chk_irq_single: assert property (
    completion_irq |=> !completion_irq) else $error("irq longer than one cycle");
  chk_clr_gated: assert property (
    $rose(clr_on) |-> ctrl_ff[`PAHC_CTRL_CLR_EN]) else $error("clear while disabled");
  chk_clr_with_irq: assert property (
    completion_irq && ctrl_ff[1] |-> clr_on) else $error("no clear at arrival");
  chk_clr_onehot: assert property (
    clr_on |-> $onehot(drive_clear_signal)) else $error("clear not one-hot");
  chk_clr_default: assert property (
    $rose(clr_on) && !ctrl_ff[2] |-> drive_clear_signal[`PAHC_DEF_CLR_ELEM])
    else $error("default clear element wrong");
  chk_clr_index: assert property (
    $rose(clr_on) && ctrl_ff[2] |-> drive_clear_signal[idx_ff])
    else $error("indexed clear element wrong");
  chk_clr_width: assert property (
    $fell(clr_on) |-> hi_ff == CLR_CYCLES + SCAN_CYCLES) else $error("clear width wrong");
  chk_step_stopped: assert property (
    $rose(clr_on) |-> !axis_pulse_output [*4]) else $error("steps during clear");
  chk_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside slot");

  cov_irq: cover property (completion_irq);
  cov_clr_on: cover property ($rose(clr_on) && ctrl_ff[2]);
  cov_clr_off: cover property ($fell(clr_on));
endmodule : pahc_axis_monitor

bind pahc_axis pahc_axis_monitor #(
  .CLR_CYCLES(CLR_CYCLES), .SCAN_CYCLES(SCAN_CYCLES), .NUM_ELEM(NUM_ELEM)
) u_mon (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .axis_pulse_output(axis_pulse_output), .drive_clear_signal(drive_clear_signal),
  .completion_irq(completion_irq)
);

// >>> tb/pahc_drive_model.sv
// Servo drive model: counts steps, reports near and zero sensor points.
// Assumes step and clear outputs of the axis; rearm starts a new trip.
`timescale 1ns/1ns
module pahc_drive_model
#(
  parameter int unsigned NEAR_AT = 4,
  parameter int unsigned ZERO_AT = 8
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Axis side
  input  wire logic        axis_pulse_output,
  input  wire logic [15:0] drive_clear_signal,
  input  wire logic        rearm,
  // Sensor side
  output logic             near_point_in,
  output logic             zero_point_in
);
  logic        step_d_ff;
  int unsigned cnt_ff;

  // Step counter, emptied by a clear pulse as a real drive does
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      step_d_ff <= 1'b0;
      cnt_ff    <= 0;
    end
    else
    begin
      step_d_ff <= axis_pulse_output;
      if (rearm || (|drive_clear_signal))
        cnt_ff <= 0;
      else if (axis_pulse_output && !step_d_ff)
        cnt_ff <= cnt_ff + 1;
    end
  end

  // Sensor points along the trip
  assign near_point_in = (cnt_ff >= NEAR_AT);
  assign zero_point_in = (cnt_ff >= ZERO_AT);
endmodule : pahc_drive_model

// >>> tb/testbench.sv
// Testbench of the homing axis: register checks and six homing runs.
// Assumes the drive model on the far side and short clear timing.
`timescale 1ns/1ns
`include "pahc_defs.svh"
module testbench;
  import pahc_pkg::*;
  logic        clk_sys, rst_b, reg_wr, reg_rd, rearm, near, zero;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, clr, clr_last, d;
  logic        pulse, dir, irq;
  int          fail_count, tests_run, cyc, irq_cnt, clr_cnt, i;
  logic [3:0]  ra [7] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h3, 4'hF};
  logic [15:0] rv [7] = '{16'h0, 16'h0, 16'h0032, 16'h01F4, 16'h0, 16'h0, 16'h0};
  logic [5:0]  tc [6] = '{6'h0B, 6'h06, 6'h1C, 6'h21, 6'h1B, 6'h1E};
  logic [1:0]  tm [6] = '{2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h3};
  logic [3:0]  ti [6] = '{4'h0, 4'h5, 4'h5, 4'h0, 4'h0, 4'hF};
  logic        td [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  // Device under test and drive model
  pahc_axis #(.CLR_CYCLES(20), .SCAN_CYCLES(5), .NUM_ELEM(16)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .near_point_in(near),
    .zero_point_in(zero), .axis_pulse_output(pulse), .axis_dir_out(dir),
    .drive_clear_signal(clr), .completion_irq(irq));
  pahc_drive_model u_drv (
    .clk_sys(clk_sys), .rst_b(rst_b), .axis_pulse_output(pulse),
    .drive_clear_signal(clr), .rearm(rearm), .near_point_in(near),
    .zero_point_in(zero));

  task automatic end_of_test;
    $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask : rd

  // One homing trip with its expected direction, irq and clear output
  task automatic run(input int k);
    logic [15:0] e;
    int          i0, c0, n;
    e  = !tc[k][1] ? 16'h0 : tc[k][2] ? 16'h1 << ti[k] : 16'h1 << `PAHC_DEF_CLR_ELEM;
    i0 = irq_cnt;
    c0 = clr_cnt;
    wr(`PAHC_REG_CLR_IDX, {12'h000, ti[k]});
    wr(`PAHC_REG_CTRL, {10'h000, tc[k]});
    @(posedge clk_sys);
    rearm <= 1'b1;
    @(posedge clk_sys);
    rearm <= 1'b0;
    wr(`PAHC_REG_CMD, {14'h0, tm[k]});
    repeat (3) @(posedge clk_sys);
    chk({15'h0, dir}, {15'h0, td[k]});
    rd(`PAHC_REG_STATUS, d);
    chk({15'h0, d[0]}, 16'h1);
    n = 0;
    while (d[3] !== 1'b1 && n < 300)
    begin
      rd(`PAHC_REG_STATUS, d);
      n++;
    end
    chk({14'h0, d[3], d[0]}, 16'h2);
    repeat (40) @(posedge clk_sys);
    chk(16'(irq_cnt - i0), {15'h0, tc[k][0]});
    chk(16'(clr_cnt - c0), (e != 0) ? 16'd25 : 16'd0);
    chk((clr_cnt == c0) ? 16'h0 : clr_last, e);
    wr(`PAHC_REG_STATUS, 16'h0008);
    rd(`PAHC_REG_STATUS, d);
    chk(d & 16'hFFFD, 16'h0);
    $display("Homing run %0d ended", k);
  endtask : run

  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Observers of irq and clear outputs, and the run limit
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (irq === 1'b1)
      irq_cnt <= irq_cnt + 1;
    if (|clr)
    begin
      clr_cnt  <= clr_cnt + 1;
      clr_last <= clr;
    end
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // Main sequence
  initial
  begin
    {rst_b, reg_wr, reg_rd, rearm, reg_addr, reg_wdata} = '0;
    {fail_count, tests_run, cyc, irq_cnt, clr_cnt} = '0;
    clr_last = '0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(4'hF, 16'hFFFF);
    for (i = 0; i < 7; i++)
    begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    wr(`PAHC_REG_CTRL, 16'h003F);
    rd(`PAHC_REG_CTRL, d);
    chk(d, 16'h003F);
    $display("Register test ended");
    wr(`PAHC_REG_FAST_HP, 16'h0002);
    wr(`PAHC_REG_CREEP_HP, 16'h0003);
    for (i = 0; i < 6; i++)
      run(i);
    end_of_test();
  end
endmodule : testbench
